/* File: hdl/gpc_pkg.sv */
/*
  Shared constants and carrier types for the gigabit PHY-side clocking
  block: code-group widths, elastic buffer sizing, idle code and clock
  rates. Assumes a single internal reference clock at 100 MHz.
*/
package gpc_pkg;

  localparam int CODE_W          = 10;
  localparam int GMII_W          = 8;
  localparam int FIFO_DEPTH      = 16;
  localparam int NEAR_FULL_LEVEL = 12;
  localparam int REF_CLOCK_MHZ   = 100;
  localparam int LINK_CLOCK_MHZ  = 125;
  localparam int TBI_RX_CLOCK_KHZ = 62500;

  // The forwarded clock cannot run faster than half the reference, so the
  // divider bottoms out at one cycle per half period.
  localparam int TX_HALF_CYCLES =
    (REF_CLOCK_MHZ >= 2 * LINK_CLOCK_MHZ) ?
    REF_CLOCK_MHZ / (2 * LINK_CLOCK_MHZ) : 1;

  // Comma-bearing idle code group, negative running disparity.
  localparam logic [CODE_W-1:0] IDLE_CODE = 10'h0FA;

  typedef struct packed {
    logic              lane;
    logic [CODE_W-1:0] code;
  } gpc_word_t;

endpackage

/* File: hdl/gpc_phy_clocking.sv */
/*
  PHY-side clocking of a gigabit MAC: forwarded transmit clock and data,
  sampling of the two receive link clocks, capture of code groups and the
  receive elastic buffer onto the reference domain.
  Assumes i_clock is the buffered reference, and that the link clocks and
  data arrive asynchronously and far slower than i_clock.
*/
// How it works
// - Transmit logic runs on the 100 MHz reference clock in either mode.
// - Forwarded transmit clock is the inverted internal transmit clock.
// - Internal transmit clock is shown to the client as a tick output.
// - Byte-wide mode receives only on the PHY receive clock edges.
// - Ten-bit mode captures groups alternately on both receive clocks.
// - Captured groups pass an elastic buffer read on the reference clock.
// - Coding sublayer configuration such as loopback steers the datapath.
// - The reference clock domain, the only one, has a single reset circuit with sync release.
`timescale 1ns/1ps
`default_nettype none

module gpc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_valid,
  output logic                          o_ready,
  input  wire logic [WIDTH-1:0]         i_data,
  output logic                          o_valid,
  input  wire logic                     i_ready,
  output logic [WIDTH-1:0]              o_data,
  output logic [$clog2(DEPTH+1)-1:0]    o_level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } gpc_fifo_state_t;

  gpc_fifo_state_t s_reg;
  gpc_fifo_state_t s_next;
  logic            push;
  logic            pop;

  assign o_ready = (s_reg.count != CW'(DEPTH));
  assign o_valid = (s_reg.count != '0);
  assign o_data  = s_reg.mem[s_reg.rd_ptr];
  assign o_level = s_reg.count;
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = i_data;
      s_next.wr_ptr = (s_reg.wr_ptr == PW'(DEPTH - 1)) ? '0 :
                      s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = (s_reg.rd_ptr == PW'(DEPTH - 1)) ? '0 :
                      s_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  property p_full_holds;
    @(posedge i_clock) disable iff (!i_rst_n)
    (!o_ready && !i_ready) |=> (o_level == $past(o_level));
  endproperty
  a_full_holds: assert property (p_full_holds)
    else $error("Buffer level changed while full and stalled.");

endmodule

////////////////////////////////////////////////////////////////////////////

module gpc_phy_clocking
  import gpc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_arst_n,
  input  wire logic                        i_tbi_mode,
  input  wire logic                        i_loopback,
  input  wire logic                        i_rx_link_clk0,
  input  wire logic                        i_rx_link_clk1,
  input  wire logic [gpc_pkg::CODE_W-1:0]  i_rx_link_data,
  input  wire logic [gpc_pkg::CODE_W-1:0]  i_tx_code,
  output logic                             o_tx_tick,
  output logic                             o_tx_link_clk,
  output logic [gpc_pkg::CODE_W-1:0]       o_tx_link_data,
  output gpc_pkg::gpc_word_t               o_rx_word,
  output logic                             o_rx_valid,
  input  wire logic                        i_rx_ready,
  output logic                             o_rx_overflow,
  output logic                             o_rx_idle_dropped,
  output logic                             o_rx_idle_inserted
);
  import gpc_pkg::*;

  localparam int HW = $clog2(TX_HALF_CYCLES + 1);
  localparam int LW = $clog2(DEPTH + 1);
  localparam int TX_PERIOD = 2 * TX_HALF_CYCLES;

  typedef struct packed {
    logic [1:0]        clk_s1;
    logic [1:0]        clk_s2;
    logic [1:0]        clk_s3;
    logic [CODE_W-1:0] dat_s1;
    logic [CODE_W-1:0] dat_s2;
    logic [HW-1:0]     div_cnt;
    logic              phase;
    logic              fwd_clk;
    logic              tick;
    logic [CODE_W-1:0] tx_data;
    logic              wr_last_idle;
    logic              rd_last_idle;
    logic              overflow;
    logic              dropped;
    logic              inserted;
  } gpc_state_t;

  gpc_state_t s_reg;
  gpc_state_t s_next;
  logic [1:0] rst_chain_reg;
  logic       rst_n;
  logic [1:0] rise;
  gpc_word_t  wr_word;
  logic       wr_valid;
  logic       wr_idle;
  logic       drop;
  logic       push;
  logic       f_ready;
  logic       f_valid;
  gpc_word_t  f_word;
  logic [LW-1:0] f_level;
  logic       insert;

  ////////////////////////////////////////////////////////////////////////
  // Assertion is asynchronous; release waits two edges so every flop of
  // the domain leaves reset on the same edge.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_chain_reg <= 2'h0;
    end else begin
      rst_chain_reg <= {rst_chain_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_chain_reg[1];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next        = s_reg;
    s_next.clk_s1 = {i_rx_link_clk1, i_rx_link_clk0};
    s_next.clk_s2 = s_reg.clk_s1;
    s_next.clk_s3 = s_reg.clk_s2;
    s_next.dat_s1 = i_rx_link_data;
    s_next.dat_s2 = s_reg.dat_s1;
    s_next.tick   = 1'b0;
    // Transmit side lives wholly on the reference clock.
    if (s_reg.div_cnt == HW'(TX_HALF_CYCLES - 1)) begin
      s_next.div_cnt = '0;
      s_next.phase   = ~s_reg.phase;
      if (!s_reg.phase) begin
        s_next.tick    = 1'b1;
        s_next.tx_data = i_tx_code;
      end
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 1'b1;
    end
    // Data changes on the forwarded falling edge, centred for the PHY.
    s_next.fwd_clk = ~s_next.phase;

    rise     = s_reg.clk_s2 & ~s_reg.clk_s3;
    wr_word  = '0;
    wr_valid = 1'b0;
    if (i_loopback) begin
      wr_valid     = s_reg.tick;
      wr_word.code = s_reg.tx_data;
    end else if (i_tbi_mode) begin
      wr_valid     = |rise;
      wr_word.lane = rise[1] & ~rise[0];
      wr_word.code = s_reg.dat_s2;
    end else begin
      wr_valid     = rise[0];
      wr_word.code = {{(CODE_W - GMII_W){1'b0}}, s_reg.dat_s2[GMII_W-1:0]};
    end

    // Only a second idle in a row is deleted, so frames stay intact.
    wr_idle = (wr_word.code == IDLE_CODE);
    drop    = wr_valid && wr_idle && s_reg.wr_last_idle &&
              (f_level >= LW'(NEAR_FULL_LEVEL));
    push    = wr_valid && !drop;
    if (wr_valid) begin
      s_next.wr_last_idle = wr_idle;
    end
    s_next.overflow = push && !f_ready;
    s_next.dropped  = drop;

    // An empty buffer after an idle repeats the idle rather than stall.
    insert = !f_valid && s_reg.rd_last_idle;
    if (f_valid) begin
      o_rx_word = f_word;
    end else begin
      o_rx_word      = '0;
      o_rx_word.code = IDLE_CODE;
    end
    o_rx_valid = f_valid || insert;
    if (o_rx_valid && i_rx_ready) begin
      s_next.rd_last_idle = (o_rx_word.code == IDLE_CODE);
    end
    s_next.inserted = insert && i_rx_ready;
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  gpc_fifo #(
    .WIDTH ($bits(gpc_word_t)),
    .DEPTH (DEPTH)
  ) u_elastic (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .i_valid (push),
    .o_ready (f_ready),
    .i_data  (wr_word),
    .o_valid (f_valid),
    .i_ready (i_rx_ready),
    .o_data  (f_word),
    .o_level (f_level)
  );

  assign o_tx_tick          = s_reg.tick;
  assign o_tx_link_clk      = s_reg.fwd_clk;
  assign o_tx_link_data     = s_reg.tx_data;
  assign o_rx_overflow      = s_reg.overflow;
  assign o_rx_idle_dropped  = s_reg.dropped;
  assign o_rx_idle_inserted = s_reg.inserted;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  property p_tick_period;
    o_tx_tick |-> ##TX_PERIOD o_tx_tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("Transmit tick period is wrong.");

  // The first edge after release still samples the all-zero reset state.
  // There the forwarded clock equals the phase, so that edge is skipped.
  property p_fwd_inverted;
    $past(rst_n) |-> o_tx_link_clk == ~s_reg.phase;
  endproperty
  a_fwd_inverted: assert property (p_fwd_inverted)
    else $error("Forwarded clock is not the inverted transmit clock.");

  // The first tick after release follows the reset low of the forwarded
  // clock, so it cannot show a fall and is left out.
  property p_tick_loads;
    ($past(rst_n, 2) && o_tx_tick) |->
      $fell(o_tx_link_clk) && o_tx_link_data == $past(i_tx_code);
  endproperty
  a_tick_loads: assert property (p_tick_loads)
    else $error("Tick did not load the client code on the clock fall.");

  property p_gmii_ignores_clk1;
    (!i_tbi_mode && !i_loopback && !rise[0]) |-> !wr_valid;
  endproperty
  a_gmii_ignores_clk1: assert property (p_gmii_ignores_clk1)
    else $error("Byte-wide mode wrote without a receive clock edge.");

  property p_tbi_lane;
    (i_tbi_mode && !i_loopback && $rose(s_reg.clk_s2[1]) &&
     !$rose(s_reg.clk_s2[0])) |-> wr_valid && wr_word.lane;
  endproperty
  a_tbi_lane: assert property (p_tbi_lane)
    else $error("Second receive clock edge did not capture a group.");

  property p_loopback;
    (i_loopback && o_tx_tick) |-> wr_valid && wr_word.code == o_tx_link_data;
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("Loopback did not route the transmit group inward.");

  property p_drop_cause;
    o_rx_idle_dropped |-> $past(f_level) >= LW'(NEAR_FULL_LEVEL) &&
                          $past(wr_word.code) == IDLE_CODE;
  endproperty
  a_drop_cause: assert property (p_drop_cause)
    else $error("Idle deleted without a near-full buffer.");

  property p_push_stored;
    (push && f_ready && !(f_valid && i_rx_ready)) |=>
      f_level == $past(f_level) + 1'b1;
  endproperty
  a_push_stored: assert property (p_push_stored)
    else $error("Captured group was not written into the buffer.");

  property p_reset_release;
    @(posedge i_clock) disable iff (!i_arst_n)
    $rose(rst_n) |-> $past(rst_chain_reg[0]) && $past(i_arst_n);
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("Domain reset released without the sync chain.");

  c_drop:     cover property (o_rx_idle_dropped);
  c_insert:   cover property (o_rx_idle_inserted);
  c_overflow: cover property (o_rx_overflow);
  c_lane1:    cover property (wr_valid && wr_word.lane);

endmodule

`default_nettype wire

/* File: testbench/gpc_link_phy_model.sv */
/*
  Behavioural model of the external PHY or serdes on the receive link:
  makes the two receive link clocks and the data, one group per call.
  Assumes the bench calls send_group in sequence; clocks rest low between.
*/
`timescale 1ns/1ps
`default_nettype none

module gpc_link_phy_model
  import gpc_pkg::*;
(
  output logic                       o_rx_clk0,
  output logic                       o_rx_clk1,
  output logic [gpc_pkg::CODE_W-1:0] o_rx_data
);

  // This model owns its own receive clocks; only the reference is shared,
  // and mode settings such as loopback come from the bench, not from here.
  initial begin
    o_rx_clk0 = 1'b0;
    o_rx_clk1 = 1'b0;
    o_rx_data = 10'h000;
  end

  ////////////////////////////////////////////////////////////////////////

  // One 80 ns period per group. The odd offsets keep link edges away from
  // the reference edges, and the data shows its inverse once released so a
  // stale group can never pass for a fresh one.
  task automatic send_group(input logic lane, input logic [CODE_W-1:0] code);
    o_rx_data = code;
    #23;
    o_rx_clk0 = ~lane;
    o_rx_clk1 = lane;
    #40;
    o_rx_clk0 = 1'b0;
    o_rx_clk1 = 1'b0;
    o_rx_data = ~code;
    #17;
  endtask

endmodule
`default_nettype wire

/* File: testbench/tb_gpc_phy_clocking.sv */
/*
  Self-checking bench for gpc_phy_clocking: receive rows in both modes,
  transmit timing, overflow, loopback, reset and idle handling.
  Assumes the link model drives the receive pins and package defaults.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_gpc_phy_clocking;
  import gpc_pkg::*;

  typedef struct packed {
    logic              tbi;
    logic              lane;
    logic [CODE_W-1:0] code;
    logic              vld;
    gpc_word_t         word;
  } gpc_row_t;

  localparam gpc_row_t ROWS [4] = '{
    '{1'b0, 1'b0, 10'h3A5, 1'b1, '{1'b0, 10'h0A5}},
    '{1'b1, 1'b0, 10'h2C3, 1'b1, '{1'b0, 10'h2C3}},
    '{1'b1, 1'b1, 10'h155, 1'b1, '{1'b1, 10'h155}},
    '{1'b0, 1'b1, 10'h0F0, 1'b0, '{1'b0, 10'h0FA}}
  };

  logic              i_clock, i_arst_n, i_tbi_mode, i_loopback, i_rx_ready;
  logic              clk0, clk1, o_tx_tick, o_tx_link_clk, o_rx_valid;
  logic              o_rx_overflow, o_rx_idle_dropped, o_rx_idle_inserted;
  logic [CODE_W-1:0] link_data, i_tx_code, o_tx_link_data;
  gpc_word_t         o_rx_word;
  int                err_total = 0, total_checks = 0;
  int                n_ovf = 0, n_drop = 0, n_ins = 0, n_tick = 0;

  gpc_link_phy_model phy (
    .o_rx_clk0 (clk0),
    .o_rx_clk1 (clk1),
    .o_rx_data (link_data)
  );

  gpc_phy_clocking dut (
    .i_clock            (i_clock),
    .i_arst_n           (i_arst_n),
    .i_tbi_mode         (i_tbi_mode),
    .i_loopback         (i_loopback),
    .i_rx_link_clk0     (clk0),
    .i_rx_link_clk1     (clk1),
    .i_rx_link_data     (link_data),
    .i_tx_code          (i_tx_code),
    .o_tx_tick          (o_tx_tick),
    .o_tx_link_clk      (o_tx_link_clk),
    .o_tx_link_data     (o_tx_link_data),
    .o_rx_word          (o_rx_word),
    .o_rx_valid         (o_rx_valid),
    .i_rx_ready         (i_rx_ready),
    .o_rx_overflow      (o_rx_overflow),
    .o_rx_idle_dropped  (o_rx_idle_dropped),
    .o_rx_idle_inserted (o_rx_idle_inserted)
  );

  // The bench clock stands in for the clean system transmit reference.
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    n_ovf  <= n_ovf + (o_rx_overflow === 1'b1);
    n_drop <= n_drop + (o_rx_idle_dropped === 1'b1);
    n_ins  <= n_ins + (o_rx_idle_inserted === 1'b1);
    n_tick <= n_tick + (o_tx_tick === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////

  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic take_word();
    @(posedge i_clock) i_rx_ready <= 1'b1;
    @(posedge i_clock) i_rx_ready <= 1'b0;
    #1;
  endtask

  task automatic run_row(input gpc_row_t r);
    int n;
    @(posedge i_clock) i_tbi_mode <= r.tbi;
    phy.send_group(r.lane, r.code);
    // The model returns on a clock edge; look once the outputs have settled.
    #1;
    n = 0;
    while (o_rx_valid !== 1'b1 && n < 8) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk(o_rx_valid === r.vld, "row valid");
    if (r.vld) begin
      chk(o_rx_word === r.word, "row word");
      take_word();
    end
  endtask

  initial begin
    #50000;
    err_total++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////

  initial begin
    int i;
    int t0;
    i_arst_n   = 1'b0;
    i_tbi_mode = 1'b0;
    i_loopback = 1'b0;
    i_rx_ready = 1'b0;
    i_tx_code  = 10'h000;
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    for (i = 0; i < 4; i++) begin
      run_row(ROWS[i]);
    end
    @(posedge i_clock) i_tx_code <= 10'h1C7;
    repeat (4) @(posedge i_clock);
    t0 = 0;
    do begin
      @(posedge i_clock);
      #1;
      t0++;
    end while (o_tx_tick !== 1'b1 && t0 < 4);
    chk(o_tx_link_data === 10'h1C7 && !o_tx_link_clk, "tx");
    @(posedge i_clock);
    #1;
    chk(o_tx_tick === 1'b0 && o_tx_link_clk === 1'b1, "fwd");
    t0 = n_tick;
    repeat (20) @(posedge i_clock);
    #1;
    chk(n_tick - t0 == 10, "tick rate");
    // Fill past the top with the consumer stalled, then drain in order.
    @(posedge i_clock) i_tbi_mode <= 1'b1;
    for (i = 0; i <= FIFO_DEPTH; i++) begin
      phy.send_group(i[0], 10'h100 + i[9:0]);
    end
    repeat (4) @(posedge i_clock);
    #1;
    chk(n_ovf == 1, "overflow");
    for (i = 0; i < FIFO_DEPTH; i++) begin
      chk(o_rx_word === {i[0], 10'h100 + i[9:0]}, "order");
      take_word();
    end
    chk(o_rx_valid === 1'b0, "empty");
    @(posedge i_clock) i_tx_code <= 10'h2AA;
    repeat (4) @(posedge i_clock);
    i_loopback <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_loopback <= 1'b0;
    repeat (3) @(posedge i_clock);
    #1;
    chk(o_rx_word === {1'b0, 10'h2AA} && o_rx_valid, "loopback");
    // A second reset in mid-run must empty the buffer of the looped-back groups.
    @(posedge i_clock) i_arst_n <= 1'b0;
    #1;
    chk(o_rx_valid === 1'b0 && o_tx_tick === 1'b0, "reset");
    chk(o_rx_word.code === IDLE_CODE && !o_tx_link_clk, "rst");
    @(posedge i_clock) i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    chk(o_rx_valid === 1'b0, "after reset");
    for (i = 0; i < NEAR_FULL_LEVEL; i++) begin
      phy.send_group(i[0], 10'h200 + i[9:0]);
    end
    phy.send_group(1'b0, IDLE_CODE);
    phy.send_group(1'b1, IDLE_CODE);
    repeat (4) @(posedge i_clock);
    #1;
    chk(n_drop == 1, "idle drop");
    for (i = 0; i <= NEAR_FULL_LEVEL; i++) begin
      take_word();
    end
    chk(o_rx_valid && o_rx_word.code === IDLE_CODE, "insert");
    take_word();
    repeat (2) @(posedge i_clock);
    chk(n_ins == 1, "inserted");
    end_of_test();
  end

endmodule
`default_nettype wire
